// ### shared/rsse_pkg.sv
// package: constants and types for the rotate/subtract/sleep execution block
`default_nettype none
package rsse_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_OPND   = 8'h04;
    localparam logic [7:0] ADDR_ACC    = 8'h08;
    localparam logic [7:0] ADDR_FILE   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_WDOG   = 8'h14;
    // ------------------------------------------------------------
    // command field layout and codes
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_DST_BIT = 4;
    localparam logic [2:0] OP_NONE  = 3'h0;
    localparam logic [2:0] OP_ROTL  = 3'h1;
    localparam logic [2:0] OP_ROTR  = 3'h2;
    localparam logic [2:0] OP_LMACC = 3'h3;
    localparam logic [2:0] OP_SLEEP = 3'h4;
    // ------------------------------------------------------------
    // status field positions, reset values and the watchdog and prescaler clear values loaded by sleep
    // ------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_HALF  = 1;
    localparam int ST_ZERO  = 2;
    localparam int ST_PD    = 3;
    localparam int ST_TO    = 4;
    localparam int ST_SLEEP = 5;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam logic       PD_RESET   = 1'b1;
    localparam logic       TO_RESET   = 1'b1;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRE_CLEAR  = 8'h00;

    typedef enum logic [2:0] {
        RSSE_NONE, RSSE_ROTL, RSSE_ROTR, RSSE_LMACC, RSSE_SLEEP
    } rsse_op_e;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       zero;
        logic       upd_half_zero;
    } rsse_alu_s;
endpackage : rsse_pkg
`default_nettype wire

// ### core/rsse_alu.sv
// module: combinational datapath for rotate and literal-minus-accumulator
`default_nettype none
module rsse_alu
    import rsse_pkg::*;
(
    input  wire rsse_pkg::rsse_op_e  op,
    input  wire logic [7:0]          operand,
    input  wire logic [7:0]          acc,
    input  wire logic                carry_in,
    output rsse_pkg::rsse_alu_s      res
);
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb
    begin
        diff  = {1'b0, operand} - {1'b0, acc};
        ndiff = {1'b0, operand[3:0]} - {1'b0, acc[3:0]};
        res   = '{result: operand, carry: carry_in, half: 1'b0, zero: 1'b0, upd_half_zero: 1'b0};
        unique case (op)
            RSSE_ROTL:
            begin
                res.result = {operand[6:0], carry_in};
                res.carry  = operand[7];
            end
            RSSE_ROTR:
            begin
                res.result = {carry_in, operand[7:1]};
                res.carry  = operand[0];
            end
            RSSE_LMACC:
            begin
                res.result        = diff[7:0];
                // no borrow means acc <= literal
                res.carry         = ~diff[8];
                res.half          = ~ndiff[4];
                res.zero          = (diff[7:0] == 8'h00);
                res.upd_half_zero = 1'b1;
            end
            RSSE_NONE, RSSE_SLEEP:
            begin
                res.result = operand;
            end
        endcase
    end
endmodule : rsse_alu
`default_nettype wire

// ### core/rsse_exec.sv
// module: apb-reached execution unit for rotate, literal subtract and sleep
//
// Our own choices: the APB register port and the register offsets.
`default_nettype none
module rsse_exec
    import rsse_pkg::*;
#(
    parameter int WDOG_W = 8,
    parameter int PRE_W  = 8
)
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    input  wire logic               wake,
    output logic                    osc_run,
    output logic [WDOG_W-1:0]       watchdog_counter,
    output logic [PRE_W-1:0]        wdog_prescale
);
    import rsse_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        acc;
        logic [7:0]        file;
        logic [7:0]        opnd;
        logic              carry_flag;
        logic              half_carry_flag;
        logic              zero_flag;
        logic              power_down_flag;
        logic              timeout_flag;
        logic              asleep;
        logic              wake_s1;
        logic              wake_s2;
        logic [WDOG_W-1:0] wdog;
        logic [PRE_W-1:0]  pre;
        logic [31:0]       rdata;
        logic              slverr;
    } rsse_state_s;

    rsse_state_s st_q;
    rsse_state_s st_d;
    rsse_alu_s   alu_res;
    rsse_op_e    op_sel;
    logic [7:0]  alu_in;
    logic        wr;
    logic        rd;
    logic [2:0]  cmd_op;
    logic        cmd_dst;

    function automatic rsse_op_e decode_op(input logic [2:0] code);
        unique case (code)
            OP_ROTL:  decode_op = RSSE_ROTL;
            OP_ROTR:  decode_op = RSSE_ROTR;
            OP_LMACC: decode_op = RSSE_LMACC;
            OP_SLEEP: decode_op = RSSE_SLEEP;
            default:  decode_op = RSSE_NONE;
        endcase
    endfunction : decode_op

    // ------------------------------------------------------------
    // apb handshake (zero wait state)
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    // error is registered in the setup cycle and shown only while the access phase stands
    assign pslverr = st_q.slverr & psel & penable;
    assign prdata  = st_q.rdata;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~penable & ~pwrite;
    assign cmd_op  = pwdata[CMD_OP_LSB +: 3];
    assign cmd_dst = pwdata[CMD_DST_BIT];
    // commands are dropped while asleep: the stopped oscillator runs nothing
    assign op_sel  = (wr && paddr == ADDR_CMD && !st_q.asleep) ? decode_op(cmd_op) : RSSE_NONE;
    // rotates act on the file register, the subtract on the literal operand
    assign alu_in  = (op_sel == RSSE_LMACC) ? st_q.opnd : st_q.file;

    rsse_alu u_alu (
        .op       (op_sel),
        .operand  (alu_in),
        .acc      (st_q.acc),
        .carry_in (st_q.carry_flag),
        .res      (alu_res)
    );

    assign osc_run          = ~st_q.asleep;
    assign watchdog_counter = st_q.wdog;
    assign wdog_prescale    = st_q.pre;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d        = st_q;
        st_d.slverr = 1'b0;
        // watchdog keeps counting while the core runs; carry out of the prescaler steps it
        if (!st_q.asleep)
        begin
            st_d.pre = st_q.pre + PRE_W'(1);
            if (&st_q.pre)
                st_d.wdog = st_q.wdog + WDOG_W'(1);
        end
        // wake is asynchronous: two flops before any logic, and only the second one is read
        st_d.wake_s1 = wake;
        st_d.wake_s2 = st_q.wake_s1;
        // wake-up is minimal: it only restarts the clock, flags keep their sleep values
        if (st_q.asleep && st_q.wake_s2)
            st_d.asleep = 1'b0;
        // ------------------------------------------------------------
        // read capture in the setup cycle, so prdata is a flop output in the access phase
        // ------------------------------------------------------------
        if (rd)
        begin
            unique case (paddr)
                ADDR_CMD:    st_d.rdata = 32'h0000_0000;
                ADDR_OPND:   st_d.rdata = {24'h00_0000, st_q.opnd};
                ADDR_ACC:    st_d.rdata = {24'h00_0000, st_q.acc};
                ADDR_FILE:   st_d.rdata = {24'h00_0000, st_q.file};
                ADDR_STATUS:
                begin
                    // flag positions come from the package so software and checker share one map
                    st_d.rdata           = 32'h0000_0000;
                    st_d.rdata[ST_CARRY] = st_q.carry_flag;
                    st_d.rdata[ST_HALF]  = st_q.half_carry_flag;
                    st_d.rdata[ST_ZERO]  = st_q.zero_flag;
                    st_d.rdata[ST_PD]    = st_q.power_down_flag;
                    st_d.rdata[ST_TO]    = st_q.timeout_flag;
                    st_d.rdata[ST_SLEEP] = st_q.asleep;
                end
                ADDR_WDOG:   st_d.rdata = 32'(st_q.wdog);
                default:
                begin
                    st_d.rdata  = 32'h0000_0000;
                    st_d.slverr = 1'b1;
                end
            endcase
        end
        if (psel && !penable && pwrite && !(paddr inside {ADDR_CMD, ADDR_OPND, ADDR_ACC, ADDR_FILE,
                                                          ADDR_STATUS, ADDR_WDOG}))
            st_d.slverr = 1'b1;
        if (wr)
        begin
            unique case (paddr)
                ADDR_OPND: st_d.opnd = pwdata[7:0];
                ADDR_ACC:  st_d.acc  = pwdata[7:0];
                ADDR_FILE: st_d.file = pwdata[7:0];
                default:   ;
            endcase
        end
        unique case (op_sel)
            RSSE_ROTL, RSSE_ROTR:
            begin
                st_d.carry_flag = alu_res.carry;
                if (cmd_dst)
                    st_d.file = alu_res.result;
                else
                    st_d.acc = alu_res.result;
            end
            RSSE_LMACC:
            begin
                st_d.acc = alu_res.result;
                st_d.carry_flag      = alu_res.carry;
                st_d.half_carry_flag = alu_res.half;
                st_d.zero_flag       = alu_res.zero;
            end
            RSSE_SLEEP:
            begin
                st_d.power_down_flag = 1'b0;
                st_d.timeout_flag    = 1'b1;
                st_d.wdog = WDOG_W'(WDOG_CLEAR);
                st_d.pre  = PRE_W'(PRE_CLEAR);
                // oscillator halted, commands ignored until wake
                st_d.asleep = 1'b1;
            end
            RSSE_NONE: ;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // everything not named below, synchroniser included, resets to zero
            st_q                 <= '0;
            st_q.acc             <= ACC_RESET;
            st_q.file            <= FILE_RESET;
            st_q.power_down_flag <= PD_RESET;
            st_q.timeout_flag    <= TO_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule : rsse_exec
`default_nettype wire

// ### testbench/rsse_exec_properties.sv
// checker: port-level properties of the execution block
`default_nettype none
module rsse_exec_properties
    import rsse_pkg::*;
#(
    parameter int WDOG_W = 8,
    parameter int PRE_W  = 8
)
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    input wire logic              wake,
    input wire logic              osc_run,
    input wire logic [WDOG_W-1:0] watchdog_counter,
    input wire logic [PRE_W-1:0]  wdog_prescale
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic acc_ph;
    logic sleep_wr;
    logic mapped;
    assign acc_ph   = psel && penable;
    assign sleep_wr = acc_ph && pwrite && paddr == ADDR_CMD && pwdata[2:0] == OP_SLEEP && osc_run;
    assign mapped   = paddr <= ADDR_WDOG && paddr[1:0] == 2'h0;
    a_sleep_osc_off: assert property (sleep_wr |=> !osc_run)
        else $error("oscillator kept running after sleep");
    a_sleep_wdog_clr: assert property (sleep_wr |=> watchdog_counter == '0 && wdog_prescale == '0)
        else $error("watchdog not cleared by sleep");
    a_asleep_wdog_held: assert property (!osc_run |-> watchdog_counter == '0 && wdog_prescale == '0)
        else $error("watchdog moved while asleep");
    a_asleep_status_bits: assert property (acc_ph && !pwrite && paddr == ADDR_STATUS && !$past(osc_run)
        |-> !prdata[ST_PD] && prdata[ST_TO] && prdata[ST_SLEEP])
        else $error("status bits wrong while asleep");
    a_prescale_step: assert property (osc_run && $past(osc_run) && !$past(reset)
        |-> wdog_prescale == PRE_W'($past(wdog_prescale) + 1'b1))
        else $error("prescaler did not step");
    a_wdog_wrap_step: assert property (osc_run && $past(osc_run) && !$past(reset) && $past(wdog_prescale) == '1
        |-> watchdog_counter == WDOG_W'($past(watchdog_counter) + 1'b1))
        else $error("watchdog did not step on prescaler wrap");
    a_read_upper_zero: assert property (acc_ph && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_err: assert property (acc_ph |-> pslverr == !mapped)
        else $error("error response does not match address");
    a_ready_high: assert property (psel |-> pready)
        else $error("ready low during transfer");
    c_sleep: cover property (sleep_wr);
    c_wake: cover property ($rose(osc_run));
    c_err: cover property (acc_ph && pslverr);
endmodule : rsse_exec_properties
bind rsse_exec rsse_exec_properties #(.WDOG_W(WDOG_W), .PRE_W(PRE_W)) chk_u (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .wake(wake), .osc_run(osc_run),
    .watchdog_counter(watchdog_counter), .wdog_prescale(wdog_prescale));
`default_nettype wire

// ### testbench/rsse_exec_bench.sv
// bench: self-checking test of the execution block
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module rsse_exec_bench
    import rsse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // stimulus and model
    // --------
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, wake = 0, pready, pslverr, osc_run;
    logic [7:0]  paddr = 8'h00, wdc, wps, acc_m = 8'h00, file_m = 8'h00, opnd_m = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        c_m = 0, h_m = 0, z_m = 0, pd_m = 1, to_m = 1, slp_m = 0;
    logic [32:0] expq[$];
    logic [32:0] exp_v;
    int          mismatches = 0, tests_run = 0, n;
    rsse_exec dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .wake(wake), .osc_run(osc_run), .watchdog_counter(wdc), .wdog_prescale(wps));
    initial begin forever #12.5 clk = ~clk; end
    function automatic logic [7:0] st();
        return {2'h0, slp_m, to_m, pd_m, z_m, h_m, c_m};
    endfunction : st
    task automatic finish_test();
        if (expq.size() != 0)
        begin
            mismatches++;
            $display("ERROR %0t: %0d reads never answered", $time, expq.size());
        end
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // the slave may stretch the access phase, so never assume a count
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t: no ready on the bus", $time);
            finish_test();
        end
        else
        begin
            psel    <= 0;
            penable <= 0;
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
        expq.push_back({err, 24'h0, e});
        apb(0, a, 32'h0);
    endtask : rd
    task automatic cmd(input logic [2:0] op, input logic d);
        logic [7:0] r;
        apb(1, ADDR_CMD, {27'h0, d, 1'b0, op});
        if (slp_m) return;
        case (op)
            OP_ROTL: begin r = {file_m[6:0], c_m}; c_m = file_m[7]; end
            OP_ROTR: begin r = {c_m, file_m[7:1]}; c_m = file_m[0]; end
            OP_LMACC: begin r = opnd_m - acc_m; c_m = acc_m <= opnd_m; h_m = acc_m[3:0] <= opnd_m[3:0];
                z_m = r == 8'h00; acc_m = r; end
            default: begin pd_m = 0; to_m = 1; slp_m = 1; end
        endcase
        if (op == OP_ROTL || op == OP_ROTR)
            if (d) file_m = r; else acc_m = r;
    endtask : cmd
    always @(posedge clk)
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            if (expq.size() == 0) begin mismatches++; $display("ERROR %0t: unexpected read", $time); end
            else
            begin
                // pop once: the macro names its arguments twice
                exp_v = expq.pop_front();
                `CHK({pslverr, prdata}, exp_v)
            end
        end
    initial
    begin
        void'($urandom(74));
        repeat (16) @(posedge clk);
        reset <= 0;
        rd(ADDR_STATUS, st(), 0);
        rd(ADDR_ACC, 8'h00, 0);
        for (int i = 0; i < 48; i++)
        begin
            acc_m = 8'($urandom); file_m = 8'($urandom);
            // every fourth pass sets literal equal to accumulator; when that pass subtracts (i % 12 == 8): zero result, both borrows clear
            opnd_m = (i % 4 == 0) ? acc_m : 8'($urandom);
            apb(1, ADDR_ACC, {24'h0, acc_m});
            apb(1, ADDR_FILE, {24'h0, file_m});
            apb(1, ADDR_OPND, {24'h0, opnd_m});
            cmd(OP_ROTL + 3'(i % 3), 1'($urandom));
            rd(ADDR_ACC, acc_m, 0);
            rd(ADDR_FILE, file_m, 0);
            rd(ADDR_STATUS, st(), 0);
        end
        rd(8'h18, 8'h00, 1);
        apb(1, 8'h22, 32'h5a);
        // op code 7 is undefined: no register or flag may move
        apb(1, ADDR_CMD, 32'h0000_0017);
        rd(ADDR_STATUS, st(), 0);
        rd(ADDR_ACC, acc_m, 0);
        cmd(OP_SLEEP, 0);
        #1 `CHK({osc_run, wdc, wps}, 17'h0)
        rd(ADDR_STATUS, st(), 0);
        rd(ADDR_WDOG, 8'h00, 0);
        cmd(OP_ROTL, 1);
        rd(ADDR_FILE, file_m, 0);
        @(posedge clk) wake <= 1;
        for (n = 0; n < 10 && osc_run !== 1'b1; n++) @(posedge clk);
        if (osc_run !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t: no wake-up", $time);
            finish_test();
        end
        else
        begin
            wake <= 0;
            slp_m = 0;
        end
        cmd(OP_ROTR, 0);
        rd(ADDR_ACC, acc_m, 0);
        rd(ADDR_STATUS, st(), 0);
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule : rsse_exec_bench
`default_nettype wire
